// File: rph_host_model.sv
// host model: reads the receive FIFO and keeps bytes written to it, up to DEPTH, until a flush clears them
module rph_host_model
  import rph_pkg::*;
#(
  parameter int DEPTH = 64
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // receive FIFO write side
  input wire logic fifo_wr,
  input wire logic [7:0] fifo_wdata,
  input wire logic fifo_flush,
  // status
  output logic overflow
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rx_q[$];

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_q.delete();
      overflow <= 1'b0;
    end else if (fifo_flush) begin
      rx_q.delete();
    end else if (fifo_wr) begin
      if (rx_q.size() >= DEPTH) begin
        overflow <= 1'b1;
      end else begin
        rx_q.push_back(fifo_wdata);
      end
    end
  end
endmodule

// File: rph_pkg.sv
// package: register map, field layout and state codes of the receive packet handler
package rph_pkg;
  // register offsets
  localparam logic [5:0] RPH_OFS_MARKER_HI = 6'h04;
  localparam logic [5:0] RPH_OFS_MARKER_LO = 6'h05;
  localparam logic [5:0] RPH_OFS_SIZE_LIMIT = 6'h06;
  localparam logic [5:0] RPH_OFS_CTRL_FIRST = 6'h07;
  localparam logic [5:0] RPH_OFS_CTRL_SECOND = 6'h08;
  localparam logic [5:0] RPH_OFS_NODE_ID = 6'h09;
  // reset values
  localparam logic [7:0] RPH_RST_MARKER_HI = 8'hd3;
  localparam logic [7:0] RPH_RST_MARKER_LO = 8'h91;
  localparam logic [7:0] RPH_RST_SIZE_LIMIT = 8'hff;
  localparam logic [7:0] RPH_RST_CTRL_FIRST = 8'h04;
  localparam logic [7:0] RPH_RST_CTRL_SECOND = 8'h45;
  localparam logic [7:0] RPH_RST_NODE_ID = 8'h00;
  // writable / readable bits, unused bits read as zero
  localparam logic [7:0] RPH_MASK_CTRL_FIRST = 8'hef;
  localparam logic [7:0] RPH_MASK_CTRL_SECOND = 8'h77;
  // field positions, first control register
  localparam int RPH_BIT_DISCARD = 3;
  localparam int RPH_BIT_TRAILER = 2;
  localparam int RPH_POS_FILTER = 0;
  // field positions, second control register
  localparam int RPH_POS_PATH = 4;
  localparam int RPH_BIT_CHKSUM_EN = 2;
  localparam int RPH_POS_SIZE_MODE = 0;
  // field codes
  localparam logic [1:0] RPH_FILT_OFF = 2'h0;
  localparam logic [1:0] RPH_FILT_NODE = 2'h1;
  localparam logic [1:0] RPH_FILT_BC0 = 2'h2;
  localparam logic [1:0] RPH_FILT_BC0_FF = 2'h3;
  localparam logic [1:0] RPH_PATH_FIFO = 2'h0;
  localparam logic [1:0] RPH_PATH_SYNC = 2'h1;
  localparam logic [1:0] RPH_PATH_ASYNC = 2'h3;
  localparam logic [1:0] RPH_SIZE_FIXED = 2'h0;
  localparam logic [1:0] RPH_SIZE_VAR = 2'h1;
  localparam logic [1:0] RPH_SIZE_INF = 2'h2;
  localparam logic [7:0] RPH_BCAST_LOW = 8'h00;
  localparam logic [7:0] RPH_BCAST_HIGH = 8'hff;
  // checksum
  localparam logic [15:0] RPH_CRC_INIT = 16'hffff;
  localparam logic [15:0] RPH_CRC_POLY = 16'h8005;

  typedef enum logic [3:0] {
    ST_HUNT = 4'h1,
    ST_BODY = 4'h2,
    ST_CHK = 4'h4,
    ST_TRAIL = 4'h8
  } rph_state_e;

  typedef struct packed {
    logic [7:0] marker_hi;
    logic [7:0] marker_lo;
    logic [7:0] size_limit;
    logic [7:0] ctrl_first;
    logic [7:0] ctrl_second;
    logic [7:0] node_id;
  } rph_regs_s;

  typedef struct packed {
    rph_regs_s regs;
    rph_state_e state;
    logic [15:0] marker_sr;
    logic [2:0] bit_cnt;
    logic [6:0] byte_sr;
    logic [7:0] byte_idx;
    logic [7:0] pkt_len;
    logic [15:0] crc;
    logic crc_ok;
    logic trail_idx;
    logic [7:0] rdata;
    logic [7:0] fifo_wdata;
    logic fifo_wr;
    logic fifo_flush;
    logic gpo0;
    logic sclk;
  } rph_state_s;
endpackage

// File: rph_rx_packet_handler.sv
// receive packet handler: marker search, length modes, node filter, checksum, trailer
// Notes on behaviour
// - search the 16-bit marker held in two registers, reset d3 and 91
// - fixed mode: every packet is exactly the stored size long, reset ff
// - discard bit set: flush the receive FIFO on checksum failure
// - trailer enable (reset on) appends signal strength and checksum-ok bytes
// - filter mode 00 off, 01 node, 10 plus 00, 11 plus 00 and ff
// - data path 00 FIFO, 01 synchronous serial, 11 asynchronous, 10 reserved
// - serial modes put received data on a general output pin, not the FIFO
// - size mode 00 uses the stored size as length
// - size mode 01 (reset) takes length from first byte after marker
// - size mode 10 receives without limit, 11 reserved
// - filter compares against an 8-bit node identity, broadcasts 00 and ff
module rph_rx_packet_handler
  import rph_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // register port
  input wire logic reg_wr_en,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // demodulated data
  input wire logic rx_bit,
  input wire logic rx_bit_valid,
  input wire logic [7:0] rssi_value,
  // receive FIFO side
  output logic fifo_wr,
  output logic [7:0] fifo_wdata,
  output logic fifo_flush,
  // serial output pins
  output logic general_output_zero,
  output logic serial_clk_out
);

  rph_state_s s_reg, s_next;

  function automatic logic filter_pass(input logic [1:0] mode, input logic [7:0] id,
                                       input logic [7:0] b);
    logic hit;
    hit = (b == id);
    if (mode == RPH_FILT_BC0) begin
      hit = hit || (b == RPH_BCAST_LOW);
    end else if (mode == RPH_FILT_BC0_FF) begin
      hit = hit || (b == RPH_BCAST_LOW) || (b == RPH_BCAST_HIGH);
    end
    return (mode == RPH_FILT_OFF) || hit;
  endfunction

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
    return {c[14:0], 1'b0} ^ ((c[15] ^ b) ? RPH_CRC_POLY : 16'h0000);
  endfunction

  logic [1:0] filt_mode, path_sel, size_mode;
  logic discard_en, trailer_en, chk_en, byte_done, fifo_path;
  logic [7:0] cur_byte, addr_idx, last_idx;
  logic [15:0] marker_cand, crc_upd;

  assign filt_mode = s_reg.regs.ctrl_first[RPH_POS_FILTER +: 2];
  assign discard_en = s_reg.regs.ctrl_first[RPH_BIT_DISCARD];
  assign trailer_en = s_reg.regs.ctrl_first[RPH_BIT_TRAILER];
  assign path_sel = s_reg.regs.ctrl_second[RPH_POS_PATH +: 2];
  assign chk_en = s_reg.regs.ctrl_second[RPH_BIT_CHKSUM_EN];
  assign size_mode = s_reg.regs.ctrl_second[RPH_POS_SIZE_MODE +: 2];
  assign fifo_path = (path_sel == RPH_PATH_FIFO);
  assign byte_done = rx_bit_valid && (s_reg.bit_cnt == 3'h7);
  assign cur_byte = {s_reg.byte_sr, rx_bit};
  assign marker_cand = {s_reg.marker_sr[14:0], rx_bit};
  assign crc_upd = crc_step(s_reg.crc, rx_bit);
  assign addr_idx = (size_mode == RPH_SIZE_VAR) ? 8'h01 : 8'h00;
  assign last_idx = (size_mode == RPH_SIZE_VAR) ? s_reg.pkt_len : s_reg.regs.size_limit - 8'h01;

  always_comb begin
    s_next = s_reg;
    s_next.fifo_wr = 1'b0;
    s_next.fifo_flush = 1'b0;
    s_next.sclk = 1'b0;
    // register writes and registered read data
    if (reg_wr_en) begin
      if (reg_addr == RPH_OFS_MARKER_HI) begin
        s_next.regs.marker_hi = reg_wdata;
      end else if (reg_addr == RPH_OFS_MARKER_LO) begin
        s_next.regs.marker_lo = reg_wdata;
      end else if (reg_addr == RPH_OFS_SIZE_LIMIT) begin
        s_next.regs.size_limit = reg_wdata;
      end else if (reg_addr == RPH_OFS_CTRL_FIRST) begin
        s_next.regs.ctrl_first = reg_wdata & RPH_MASK_CTRL_FIRST;
      end else if (reg_addr == RPH_OFS_CTRL_SECOND) begin
        s_next.regs.ctrl_second = reg_wdata & RPH_MASK_CTRL_SECOND;
      end else if (reg_addr == RPH_OFS_NODE_ID) begin
        s_next.regs.node_id = reg_wdata;
      end
    end
    if (reg_addr == RPH_OFS_MARKER_HI) begin
      s_next.rdata = s_reg.regs.marker_hi;
    end else if (reg_addr == RPH_OFS_MARKER_LO) begin
      s_next.rdata = s_reg.regs.marker_lo;
    end else if (reg_addr == RPH_OFS_SIZE_LIMIT) begin
      s_next.rdata = s_reg.regs.size_limit;
    end else if (reg_addr == RPH_OFS_CTRL_FIRST) begin
      s_next.rdata = s_reg.regs.ctrl_first;
    end else if (reg_addr == RPH_OFS_CTRL_SECOND) begin
      s_next.rdata = s_reg.regs.ctrl_second;
    end else if (reg_addr == RPH_OFS_NODE_ID) begin
      s_next.rdata = s_reg.regs.node_id;
    end else begin
      s_next.rdata = 8'h00;
    end
    if (!fifo_path && rx_bit_valid) begin
      s_next.gpo0 = rx_bit;
      s_next.sclk = (path_sel == RPH_PATH_SYNC);
    end
    if (!fifo_path) begin
      s_next.state = ST_HUNT;
      s_next.marker_sr = 16'h0000;
    end else if (rx_bit_valid || s_reg.state == ST_TRAIL) begin
      if (rx_bit_valid) begin
        s_next.bit_cnt = s_reg.bit_cnt + 3'h1;
        s_next.byte_sr = cur_byte[6:0];
        if (chk_en) begin
          s_next.crc = crc_upd;
        end
      end
      case (s_reg.state)
        ST_HUNT: begin
          s_next.marker_sr = marker_cand;
          if (marker_cand == {s_reg.regs.marker_hi, s_reg.regs.marker_lo}) begin
            s_next.state = ST_BODY;
            s_next.bit_cnt = 3'h0;
            s_next.byte_idx = 8'h00;
            s_next.crc = RPH_CRC_INIT;
            s_next.marker_sr = 16'h0000;
          end
        end
        ST_BODY: begin
          if (byte_done) begin
            s_next.fifo_wr = 1'b1;
            s_next.fifo_wdata = cur_byte;
            s_next.byte_idx = s_reg.byte_idx + 8'h01;
            if (size_mode == RPH_SIZE_VAR && s_reg.byte_idx == 8'h00) begin
              s_next.pkt_len = cur_byte;
              if (cur_byte == 8'h00 || cur_byte > s_reg.regs.size_limit) begin
                s_next.fifo_flush = 1'b1;
                s_next.state = ST_HUNT;
              end
            end else if (filt_mode != RPH_FILT_OFF && s_reg.byte_idx == addr_idx &&
                         !filter_pass(filt_mode, s_reg.regs.node_id, cur_byte)) begin
              s_next.fifo_flush = 1'b1;
              s_next.state = ST_HUNT;
            end
            if (size_mode != RPH_SIZE_INF && s_reg.byte_idx == last_idx &&
                !(size_mode == RPH_SIZE_VAR && s_reg.byte_idx == 8'h00) &&
                s_next.state == ST_BODY) begin
              s_next.byte_idx = 8'h00;
              if (chk_en) begin
                s_next.state = ST_CHK;
              end else if (trailer_en) begin
                s_next.crc_ok = 1'b0;
                s_next.state = ST_TRAIL;
              end else begin
                s_next.state = ST_HUNT;
              end
            end
          end
        end
        ST_CHK: begin
          if (byte_done) begin
            s_next.byte_idx = s_reg.byte_idx + 8'h01;
            if (s_reg.byte_idx == 8'h01) begin
              s_next.crc_ok = (crc_upd == 16'h0000);
              s_next.trail_idx = 1'b0;
              s_next.fifo_flush = discard_en && (crc_upd != 16'h0000) && !trailer_en;
              s_next.state = trailer_en ? ST_TRAIL : ST_HUNT;
            end
          end
        end
        ST_TRAIL: begin
          s_next.fifo_wr = 1'b1;
          s_next.trail_idx = 1'b1;
          s_next.fifo_wdata = s_reg.trail_idx ? {s_reg.crc_ok, 7'h00} : rssi_value;
          if (s_reg.trail_idx) begin
            s_next.fifo_flush = discard_en && chk_en && !s_reg.crc_ok;
            s_next.state = ST_HUNT;
            s_next.trail_idx = 1'b0;
          end
        end
        default: begin
          s_next.state = ST_HUNT;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_reg <= '0;
      s_reg.state <= ST_HUNT;
      s_reg.regs.marker_hi <= RPH_RST_MARKER_HI;
      s_reg.regs.marker_lo <= RPH_RST_MARKER_LO;
      s_reg.regs.size_limit <= RPH_RST_SIZE_LIMIT;
      s_reg.regs.ctrl_first <= RPH_RST_CTRL_FIRST;
      s_reg.regs.ctrl_second <= RPH_RST_CTRL_SECOND;
      s_reg.regs.node_id <= RPH_RST_NODE_ID;
    end else begin
      s_reg <= s_next;
    end
  end

  assign reg_rdata = s_reg.rdata;
  assign fifo_wr = s_reg.fifo_wr;
  assign fifo_wdata = s_reg.fifo_wdata;
  assign fifo_flush = s_reg.fifo_flush;
  assign general_output_zero = s_reg.gpo0;
  assign serial_clk_out = s_reg.sclk;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  AST_MARKER_HIT: assert property (
    s_reg.state == ST_HUNT && fifo_path && rx_bit_valid &&
    marker_cand == {s_reg.regs.marker_hi, s_reg.regs.marker_lo} |=> s_reg.state == ST_BODY)
    else $error("marker match did not start a packet");
  AST_FIXED_END: assert property (
    s_reg.state == ST_BODY && fifo_path && size_mode == RPH_SIZE_FIXED && byte_done &&
    s_reg.byte_idx == s_reg.regs.size_limit - 8'h01 |=> s_reg.state != ST_BODY)
    else $error("fixed size packet did not end at stored size");
  AST_VAR_LIMIT: assert property (
    s_reg.state == ST_BODY && fifo_path && size_mode == RPH_SIZE_VAR && byte_done &&
    s_reg.byte_idx == 8'h00 && cur_byte > s_reg.regs.size_limit
    |=> fifo_flush && s_reg.state == ST_HUNT)
    else $error("oversize variable length not dropped");
  AST_VAR_LEN: assert property (
    s_reg.state == ST_BODY && fifo_path && size_mode == RPH_SIZE_VAR && byte_done &&
    s_reg.byte_idx == 8'h00 |=> s_reg.pkt_len == $past(cur_byte))
    else $error("length byte not captured");
  AST_INFINITE: assert property (
    s_reg.state == ST_BODY && fifo_path && size_mode == RPH_SIZE_INF && byte_done
    && filt_mode == RPH_FILT_OFF |=> s_reg.state == ST_BODY ##1 s_reg.state == ST_BODY)
    else $error("infinite mode left the body");
  AST_DISCARD: assert property (
    s_reg.state == ST_CHK && fifo_path && byte_done && s_reg.byte_idx == 8'h01 &&
    discard_en && !trailer_en && crc_upd != 16'h0000 |=> fifo_flush)
    else $error("bad checksum packet not flushed");
  AST_TRAILER: assert property (
    s_reg.state == ST_TRAIL && !s_reg.trail_idx && fifo_path
    |=> fifo_wr && fifo_wdata == $past(rssi_value) ##1 fifo_wr && fifo_wdata[6:0] == 7'h00)
    else $error("status trailer bytes wrong");
  AST_FILTER: assert property (
    s_reg.state == ST_BODY && fifo_path && byte_done && filt_mode != RPH_FILT_OFF &&
    size_mode == RPH_SIZE_FIXED && s_reg.byte_idx == 8'h00 && cur_byte != s_reg.regs.node_id &&
    cur_byte != RPH_BCAST_LOW && cur_byte != RPH_BCAST_HIGH |=> fifo_flush)
    else $error("foreign node packet accepted");
  AST_SERIAL: assert property (
    !fifo_path && rx_bit_valid |=> general_output_zero == $past(rx_bit) && !fifo_wr)
    else $error("serial mode data not on output pin");
  AST_NO_CHK: assert property (
    s_reg.state == ST_BODY && !chk_en |=> s_reg.state != ST_CHK)
    else $error("checksum phase entered while disabled");

  COV_FIXED_PKT: cover property (s_reg.state == ST_BODY && size_mode == RPH_SIZE_FIXED
    ##1 s_reg.state == ST_CHK);
  COV_TRAILER: cover property (s_reg.state == ST_TRAIL ##1 s_reg.state == ST_TRAIL);
  COV_FLUSH: cover property (fifo_flush);
  COV_SYNC_SERIAL: cover property (serial_clk_out);

endmodule

// File: rph_rx_packet_handler_bench.sv
// bench: register, framing, filter, checksum and serial checks against a queue model
`define CHK(nm, e, g) begin \
  comparisons++; \
  if ((g) !== (e)) begin \
    n_mismatch++; \
    $display("mismatch %s exp %h got %h", nm, e, g); \
  end \
end
module rph_rx_packet_handler_bench
  import rph_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic reg_wr_en = 1'b0;
  logic [5:0] reg_addr = 6'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic rx_bit = 1'b0;
  logic rx_bit_valid = 1'b0;
  logic [7:0] rssi_value = 8'h00;
  logic [7:0] reg_rdata, fifo_wdata;
  logic fifo_wr, fifo_flush, general_output_zero, serial_clk_out, overflow;
  int n_mismatch = 0;
  int comparisons = 0;
  logic [15:0] lfsr_reg = 16'habf0;
  logic [15:0] mk = 16'hd391;
  logic [7:0] pkt_q[$];
  logic [7:0] exp_q[$];
  logic [5:0] rst_addr [7] = '{6'h04, 6'h05, 6'h06, 6'h07, 6'h08, 6'h09, 6'h0a};
  logic [7:0] rst_val [7] = '{8'hd3, 8'h91, 8'hff, 8'h04, 8'h45, 8'h00, 8'h00};
  logic [7:0] fl_addr [4] = '{8'h5a, 8'h00, 8'hff, 8'h33};
  int vlen [4] = '{1, 4, 5, 0};

  rph_rx_packet_handler DUT (.sys_clk(sys_clk), .arst_n(arst_n), .reg_wr_en(reg_wr_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .rx_bit(rx_bit),
    .rx_bit_valid(rx_bit_valid), .rssi_value(rssi_value), .fifo_wr(fifo_wr),
    .fifo_wdata(fifo_wdata), .fifo_flush(fifo_flush),
    .general_output_zero(general_output_zero), .serial_clk_out(serial_clk_out));
  rph_host_model HOST (.sys_clk(sys_clk), .arst_n(arst_n), .fifo_wr(fifo_wr),
    .fifo_wdata(fifo_wdata), .fifo_flush(fifo_flush), .overflow(overflow));

  always #20 sys_clk = ~sys_clk;

  function automatic logic [7:0] rnd8();
    lfsr_reg = {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
    return lfsr_reg[7:0];
  endfunction

  function automatic logic [15:0] crc16(input logic [7:0] a, input logic [7:0] b);
    logic [15:0] c;
    logic [15:0] d;
    c = 16'hffff;
    d = {a, b};
    for (int i = 15; i >= 0; i--) c = (c << 1) ^ ((c[15] ^ d[i]) ? 16'h8005 : 16'h0000);
    return c;
  endfunction

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_wr_en = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge sys_clk);
    reg_wr_en = 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask

  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      @(negedge sys_clk);
      rx_bit = b[i];
      rx_bit_valid = 1'b1;
    end
  endtask

  // idle line carries noise, not the last bit
  task automatic idle(input int n);
    repeat (n) begin
      @(negedge sys_clk);
      rx_bit_valid = 1'b0;
      rx_bit = rnd8() > 8'h7f;
    end
  endtask

  function automatic void exp_trail(input logic ok);
    exp_q.push_back(rssi_value);
    exp_q.push_back({ok, 7'h00});
  endfunction

  task automatic run_pkt(input string nm);
    send_byte(mk[15:8]);
    send_byte(mk[7:0]);
    foreach (pkt_q[i]) send_byte(pkt_q[i]);
    idle(8);
    `CHK({nm, " count"}, exp_q.size(), HOST.rx_q.size())
    for (int i = 0; i < exp_q.size() && i < HOST.rx_q.size(); i++) begin
      `CHK(nm, exp_q[i], HOST.rx_q[i])
    end
    HOST.rx_q.delete();
    exp_q.delete();
    pkt_q.delete();
  endtask

  initial begin
    repeat (100000) @(posedge sys_clk);
    n_mismatch++;
    end_sim();
  end

  initial begin
    logic [7:0] r, a, b;
    logic [15:0] c;
    logic ok;
    repeat (12) @(negedge sys_clk);
    arst_n = 1'b1;
    for (int i = 0; i < 7; i++) begin
      rd(rst_addr[i], r);
      `CHK("reset value", rst_val[i], r)
    end
    wr(6'h07, 8'hff);
    rd(6'h07, r);
    `CHK("first control mask", 8'hef, r)
    wr(6'h08, 8'hff);
    rd(6'h08, r);
    `CHK("second control mask", 8'h77, r)
    wr(6'h0a, 8'h5a);
    rd(6'h0a, r);
    `CHK("unmapped", 8'h00, r)
    $display("test registers done");
    // new marker, fixed size three, trailer on then off
    wr(6'h04, 8'h5a);
    wr(6'h05, 8'ha5);
    mk = 16'h5aa5;
    wr(6'h08, 8'h00);
    wr(6'h06, 8'h03);
    for (int t = 0; t < 2; t++) begin
      wr(6'h07, t ? 8'h00 : 8'h04);
      rssi_value = rnd8();
      repeat (3) pkt_q.push_back(rnd8());
      exp_q = pkt_q;
      if (t == 0) exp_trail(1'b0);
      run_pkt("fixed");
    end
    $display("test fixed done");
    wr(6'h07, 8'h04);
    wr(6'h08, 8'h01);
    wr(6'h06, 8'h04);
    foreach (vlen[k]) begin
      rssi_value = rnd8();
      pkt_q.push_back(vlen[k][7:0]);
      if (vlen[k] > 0 && vlen[k] <= 4) begin
        repeat (vlen[k]) pkt_q.push_back(rnd8());
        exp_q = pkt_q;
        exp_trail(1'b0);
      end
      run_pkt("variable");
    end
    $display("test variable done");
    wr(6'h08, 8'h00);
    wr(6'h06, 8'h02);
    wr(6'h09, 8'h5a);
    for (int m = 0; m < 4; m++) begin
      wr(6'h07, 8'h04 | m[7:0]);
      foreach (fl_addr[j]) begin
        a = fl_addr[j];
        rssi_value = rnd8();
        pkt_q = '{a, rnd8()};
        ok = m == 0 || a == 8'h5a || (m >= 2 && a == 8'h00) || (m == 3 && a == 8'hff);
        if (ok) exp_q = pkt_q;
        if (ok) exp_trail(1'b0);
        run_pkt("filter");
      end
    end
    // address byte follows the length byte in variable mode
    wr(6'h08, 8'h01);
    wr(6'h06, 8'h04);
    for (int j = 0; j < 2; j++) begin
      rssi_value = rnd8();
      pkt_q = '{8'h02, j ? 8'h5a : 8'h33, rnd8()};
      if (j) exp_q = pkt_q;
      if (j) exp_trail(1'b0);
      run_pkt("variable filter");
    end
    wr(6'h06, 8'h02);
    $display("test filter done");
    wr(6'h08, 8'h04);
    for (int k = 0; k < 4; k++) begin
      wr(6'h07, k == 2 ? 8'h04 : (k == 3 ? 8'h08 : 8'h0c));
      rssi_value = rnd8();
      a = rnd8();
      b = rnd8();
      c = crc16(a, b);
      pkt_q = '{a, b, c[15:8], c[7:0] ^ {7'h00, k > 0}};
      if (!k[0]) exp_q = '{a, b};
      if (!k[0]) exp_trail(k == 0);
      run_pkt("checksum");
    end
    $display("test checksum done");
    for (int p = 1; p < 4; p += 2) begin
      wr(6'h08, p[3:0] << 4);
      repeat (16) begin
        ok = rnd8() > 8'h7f;
        @(negedge sys_clk);
        rx_bit = ok;
        rx_bit_valid = 1'b1;
        @(negedge sys_clk);
        rx_bit_valid = 1'b0;
        `CHK("serial data", ok, general_output_zero)
        `CHK("serial clock", p == 1, serial_clk_out)
      end
      `CHK("serial fifo", 0, HOST.rx_q.size())
    end
    $display("test serial done");
    wr(6'h08, 8'h02);
    repeat (6) pkt_q.push_back(rnd8());
    exp_q = pkt_q;
    run_pkt("infinite");
    wr(6'h08, 8'h00);
    $display("test infinite done");
    `CHK("overflow", 1'b0, overflow)
    end_sim();
  end
endmodule
